// >>> verilog/rbc_pkg.sv
/*
 * Shared constants for the reset-source and brown-out control block:
 * register indices, field positions, reset values, filter and sampling counts.
 * Assumes a single system clock domain at 250 MHz.
 */
package rbc_pkg;
    // Printed offsets are register indices; the byte address is four times the index
    localparam logic [7:0] RBC_IDX_PWR   = 8'h87;
    localparam logic [7:0] RBC_IDX_AUX   = 8'ha2;
    localparam logic [7:0] RBC_IDX_BOD0  = 8'ha3;
    localparam logic [7:0] RBC_IDX_BOD1  = 8'hab;
    localparam int         RBC_ADDR_W    = 10;

    localparam int RBC_PWR_COLD    = 4;
    localparam int RBC_PWR_RSVD    = 5;
    localparam int RBC_B0_DET_EN   = 7;
    localparam int RBC_B0_THR_LO   = 4;
    localparam int RBC_B0_EVT      = 3;
    localparam int RBC_B0_RST_EN   = 2;
    localparam int RBC_B0_RST_FLAG = 1;
    localparam int RBC_B0_STAT     = 0;
    localparam int RBC_B1_MODE_LO  = 1;
    localparam int RBC_B1_FILT     = 0;
    localparam int RBC_AUX_PIN     = 6;
    localparam int RBC_CFG_DET_EN  = 7;
    localparam int RBC_CFG_THR_LO  = 4;
    localparam int RBC_CFG_RST_EN  = 2;

    localparam logic [7:0]  RBC_PWR_RST      = 8'h00;
    localparam logic [1:0]  RBC_MODE_RST     = 2'h0;
    localparam logic        RBC_FILT_RST     = 1'h1;
    localparam logic [15:0] RBC_RESET_VECTOR = 16'h0000;

    // Counts in system clocks or slow oscillator ticks
    localparam logic [4:0] RBC_PIN_MIN_CYC = 5'h18;
    localparam logic [5:0] RBC_FAST_FILT   = 6'h20;
    localparam logic [5:0] RBC_SLOW_FILT   = 6'h02;
    localparam logic [8:0] RBC_LP1_TICKS   = 9'h010;
    localparam logic [8:0] RBC_LP2_TICKS   = 9'h040;
    localparam logic [8:0] RBC_LP3_TICKS   = 9'h100;

    localparam logic [1:0] RBC_SM_CONT = 2'h0;
    localparam logic [1:0] RBC_SM_LP1  = 2'h1;
    localparam logic [1:0] RBC_SM_LP2  = 2'h2;

    typedef enum logic [1:0] {RBC_PIN_IDLE, RBC_PIN_COUNT, RBC_PIN_RESET} rbc_pin_st_t;

    function automatic logic [8:0] rbc_interval(input logic [1:0] mode);
        unique case (mode)
            RBC_SM_LP1: rbc_interval = RBC_LP1_TICKS;
            RBC_SM_LP2: rbc_interval = RBC_LP2_TICKS;
            default:    rbc_interval = RBC_LP3_TICKS;
        endcase
    endfunction : rbc_interval
endpackage : rbc_pkg

// >>> verilog/rbc_sampler.sv
/*
 * Periodic sampler for the supply detector in its low-power modes.
 * Assumes slow_internal_osc_tick is a one-cycle pulse per slow oscillator period.
 */
`timescale 1ns/1ns
module rbc_sampler import rbc_pkg::*; (
    input  wire logic       mclk,      // System clock
    input  wire logic       rstn,      // Synchronous reset, active low
    input  wire logic       slow_internal_osc_tick, // One pulse per slow oscillator period
    input  wire logic       det_en,    // Detector switched on
    input  wire logic [1:0] mode,      // Sampling mode
    input  wire logic       level_in,  // Synchronised detector level
    output logic            sampled    // Held detector level
);
    logic [8:0] tick_cnt;
    wire logic [8:0] last = rbc_interval(mode) - 9'h001;
    wire logic       cont = (mode == RBC_SM_CONT);
    wire logic       take = cont | (slow_internal_osc_tick & (tick_cnt >= last));

    always_ff @(posedge mclk) begin
        if (!rstn || !det_en || cont) begin
            tick_cnt <= 9'h000;
        end else if (slow_internal_osc_tick) begin
            tick_cnt <= take ? 9'h000 : tick_cnt + 9'h001;
        end
    end

    // Between samples the detector is off, so its last verdict is held
    always_ff @(posedge mclk) begin
        if (!rstn || !det_en) begin
            sampled <= 1'h0;
        end else if (take) begin
            sampled <= level_in;
        end
    end

    property p_lp_hold;
        @(posedge mclk) disable iff (!rstn)
        (det_en && !cont && !take) |=> (sampled == $past(sampled) || !det_en);
    endproperty
    a_lp_hold: assert property (p_lp_hold)
        else $error("sampled level changed between samples");
endmodule : rbc_sampler

// >>> verilog/rbc_filter.sv
/*
 * Noise filter for the detector level: a change must persist for a
 * number of system clocks or slow oscillator ticks before it is passed.
 * Assumes use_fast and slow_internal_osc_tick come from the same clock domain.
 */
`timescale 1ns/1ns
module rbc_filter import rbc_pkg::*; (
    input  wire logic mclk,      // System clock
    input  wire logic rstn,      // Synchronous reset, active low
    input  wire logic slow_internal_osc_tick, // One pulse per slow oscillator period
    input  wire logic filt_en,   // Filter enabled
    input  wire logic use_fast,  // Count system clocks instead of slow ticks
    input  wire logic level_in,  // Sampled detector level
    output logic      level_out  // Filtered detector level
);
    logic [5:0] cnt;
    wire logic [5:0] limit  = use_fast ? RBC_FAST_FILT : RBC_SLOW_FILT;
    wire logic       step   = use_fast | slow_internal_osc_tick;
    wire logic       differ = (level_in != level_out);
    wire logic       done   = step & (cnt == limit - 6'h01);

    always_ff @(posedge mclk) begin
        if (!rstn || !filt_en || !differ) begin
            cnt <= 6'h00;
        end else if (step) begin
            cnt <= done ? 6'h00 : cnt + 6'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            level_out <= 1'h0;
        end else if (!filt_en || (differ && done)) begin
            level_out <= level_in;
        end
    end

    property p_filt_off;
        @(posedge mclk) disable iff (!rstn)
        !filt_en |=> level_out == $past(level_in);
    endproperty
    a_filt_off: assert property (p_filt_off)
        else $error("unfiltered level not passed in one cycle");

    property p_fast_hold;
        @(posedge mclk) disable iff (!rstn)
        (filt_en && use_fast && !differ) ##1 (filt_en && use_fast && differ)
            |-> ##1 (level_out == $past(level_out));
    endproperty
    a_fast_hold: assert property (p_fast_hold)
        else $error("filter passed a one-cycle change");
endmodule : rbc_filter

// >>> verilog/rbc_ctrl.sv
/*
 * Reset-source and brown-out control: detector sampling and filtering,
 * brown-out and pin reset generation, sticky source flags, AHB-Lite registers.
 * Assumes rstn is the power-on reset, and that config word, clock status,
 * power state and timed-access window come from logic on mclk.
 */
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module rbc_ctrl import rbc_pkg::*; (
    input  wire logic                  mclk,          // System clock, 250 MHz
    input  wire logic                  rstn,          // Power-on reset, sync, active low
    input  wire logic                  hsel,          // AHB slave select
    input  wire logic [RBC_ADDR_W-1:0] haddr,         // AHB byte address
    input  wire logic [1:0]            htrans,        // AHB transfer type
    input  wire logic                  hwrite,        // AHB write
    input  wire logic [2:0]            hsize,         // AHB size, word only
    input  wire logic [31:0]           hwdata,        // AHB write data
    input  wire logic                  hready,        // AHB bus ready
    output logic                       hreadyout,     // AHB slave ready
    output logic [31:0]                hrdata,        // AHB read data
    output logic                       hresp,         // AHB response, always OKAY
    input  wire logic                  undervolt_raw, // Comparator: supply below threshold
    input  wire logic                  rst_pin_n,     // External reset pin, active low
    input  wire logic                  slow_osc_clk,  // Slow oscillator, as data
    input  wire logic [7:0]            nv_config,     // Nonvolatile config word
    input  wire logic                  clk_is_slow,   // System clock is slow oscillator
    input  wire logic                  cpu_powerdown, // CPU halted in power-down
    input  wire logic                  clk_stable,    // Restarted clock is stable
    input  wire logic                  ta_unlock,     // Timed-access unlock window open
    input  wire logic                  irq_allowed,   // Interrupt enables set
    output logic                       sys_rst_n,     // System reset, active low
    output logic [15:0]                boot_addr,     // Execution start address
    output logic                       clk_wake_req,  // Asynchronous clock restart
    output logic                       undervolt_irq, // Brown-out interrupt request
    output logic [1:0]                 threshold_sel  // Selected detector threshold
);
    function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction : hit

    // Two-flop synchronisers for detector, pin and slow oscillator
    logic [2:0] sync1;
    logic [2:0] sync2;
    wire logic [2:0] async_in = {slow_osc_clk, rst_pin_n, undervolt_raw};
    // Pin stages reset high, its idle level, so leaving reset shows no false press
    localparam logic [2:0] SYNC_IDLE = 3'h2;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    sync1[gi] <= SYNC_IDLE[gi];
                    sync2[gi] <= SYNC_IDLE[gi];
                end else begin
                    sync1[gi] <= async_in[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate
    logic slow_internal_osc_prev;
    always_ff @(posedge mclk) begin
        slow_internal_osc_prev <= rstn ? sync2[2] : 1'h0;
    end
    wire logic below     = sync2[0];
    wire logic pin_low   = ~sync2[1];
    wire logic slow_internal_osc_tick = sync2[2] & ~slow_internal_osc_prev;

    // Register state
    logic [7:0] pwr_bits;
    logic       cold_start_flag;
    logic       detector_enable;
    logic [1:0] thr_sel;
    logic       undervolt_event_flag;
    logic       undervolt_reset_enable;
    logic       undervolt_reset_flag;
    logic [1:0] detector_sampling_mode;
    logic       detector_filter_enable;
    logic       pin_reset_flag;

    // Detector path
    logic sampled;
    logic filtered;
    wire logic use_fast = ~clk_is_slow & (detector_sampling_mode == RBC_SM_CONT)
                        & ~cpu_powerdown;
    rbc_sampler u_sampler (
        .mclk      (mclk),
        .rstn      (rstn),
        .slow_internal_osc_tick (slow_internal_osc_tick),
        .det_en    (detector_enable),
        .mode      (detector_sampling_mode),
        .level_in  (below),
        .sampled   (sampled)
    );
    rbc_filter u_filter (
        .mclk      (mclk),
        .rstn      (rstn),
        .slow_internal_osc_tick (slow_internal_osc_tick),
        .filt_en   (detector_filter_enable),
        .use_fast  (use_fast),
        .level_in  (sampled),
        .level_out (filtered)
    );
    wire logic status = detector_enable & filtered;
    logic status_prev;
    always_ff @(posedge mclk) begin
        status_prev <= rstn ? status : 1'h0;
    end
    wire logic crossing = status ^ status_prev;
    wire logic bor_rst  = status & undervolt_reset_enable;

    // Pin reset detector; the counter only runs once the clock is trusted
    rbc_pin_st_t pin_st;
    rbc_pin_st_t next_pin_st;
    logic [4:0]  pin_cnt;
    wire logic clk_ok  = ~cpu_powerdown | clk_stable;
    wire logic pin_rst = (pin_st == RBC_PIN_RESET);
    always_comb begin
        next_pin_st = pin_st;
        unique case (pin_st)
            RBC_PIN_IDLE:  if (pin_low && clk_ok) next_pin_st = RBC_PIN_COUNT;
            RBC_PIN_COUNT: begin
                if (!pin_low) begin
                    next_pin_st = RBC_PIN_IDLE;
                end else if (pin_cnt == RBC_PIN_MIN_CYC - 5'h01) begin
                    next_pin_st = RBC_PIN_RESET;
                end
            end
            RBC_PIN_RESET: if (!pin_low) next_pin_st = RBC_PIN_IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        pin_st  <= rstn ? next_pin_st : RBC_PIN_IDLE;
        pin_cnt <= (rstn && pin_st == RBC_PIN_COUNT) ? pin_cnt + 5'h01 : 5'h01;
    end
    // The pin wakes a stopped clock without waiting for any edge
    assign clk_wake_req = cpu_powerdown & ~rst_pin_n;

    // Merged system reset; hard fault, watchdog and software sources live elsewhere
    always_ff @(posedge mclk) begin
        sys_rst_n <= rstn & ~bor_rst & ~pin_rst;
        boot_addr <= RBC_RESET_VECTOR;
    end
    wire logic any_rst = ~rstn | ~sys_rst_n;

    // AHB-Lite slave: writes without wait, reads with one wait state
    logic       dph_valid;
    logic       dph_write;
    logic       rd_done;
    logic [7:0] dph_idx;
    wire logic take_ap = hsel & hready & htrans[1];
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dph_valid <= 1'h0;
            dph_write <= 1'h0;
            dph_idx   <= 8'h00;
        end else if (hready) begin
            dph_valid <= take_ap;
            dph_write <= hwrite;
            dph_idx   <= (haddr[1:0] == 2'h0) ? haddr[9:2] : 8'h00;
        end
    end
    wire logic rd_wait = dph_valid & ~dph_write & ~rd_done;
    assign hreadyout = ~rd_wait;
    assign hresp     = 1'h0;
    wire logic wr    = dph_valid & dph_write;
    wire logic wr_pwr  = wr & hit(dph_idx, RBC_IDX_PWR);
    wire logic wr_aux  = wr & hit(dph_idx, RBC_IDX_AUX);
    wire logic wr_bod0 = wr & hit(dph_idx, RBC_IDX_BOD0) & ta_unlock;
    wire logic wr_bod1 = wr & hit(dph_idx, RBC_IDX_BOD1) & ta_unlock;
    wire logic [7:0] wd = hwdata[7:0];

    wire logic [7:0] rd_pwr  = {pwr_bits[7:6], 1'h0, cold_start_flag, pwr_bits[3:0]};
    wire logic [7:0] rd_bod0 = {detector_enable, 1'h0, thr_sel, undervolt_event_flag,
                                undervolt_reset_enable, undervolt_reset_flag, status};
    wire logic [7:0] rd_bod1 = {5'h00, detector_sampling_mode, detector_filter_enable};
    wire logic [7:0] rd_aux  = {1'h0, pin_reset_flag, 6'h00};
    wire logic [7:0] rd_mux  = hit(dph_idx, RBC_IDX_PWR)  ? rd_pwr  :
                               hit(dph_idx, RBC_IDX_BOD0) ? rd_bod0 :
                               hit(dph_idx, RBC_IDX_BOD1) ? rd_bod1 :
                               hit(dph_idx, RBC_IDX_AUX)  ? rd_aux  : 8'h00;
    always_ff @(posedge mclk) begin
        rd_done <= rstn & rd_wait;
        if (!rstn) begin
            hrdata <= 32'h00000000;
        end else if (rd_wait) begin
            hrdata <= {24'h000000, rd_mux};
        end
    end

    // Power control: cold-start flag survives every reset but power-on
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cold_start_flag <= 1'h1;
        end else if (wr_pwr) begin
            cold_start_flag <= wd[RBC_PWR_COLD];
        end
    end
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            pwr_bits <= RBC_PWR_RST;
        end else if (wr_pwr) begin
            pwr_bits <= wd & ~(8'h01 << RBC_PWR_RSVD) & ~(8'h01 << RBC_PWR_COLD);
        end
    end

    // Primary detector control, reloaded from configuration on every reset
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            detector_enable        <= nv_config[RBC_CFG_DET_EN];
            thr_sel                <= nv_config[RBC_CFG_THR_LO +: 2];
            undervolt_reset_enable <= nv_config[RBC_CFG_RST_EN];
        end else if (wr_bod0) begin
            detector_enable        <= wd[RBC_B0_DET_EN];
            thr_sel                <= wd[RBC_B0_THR_LO +: 2];
            undervolt_reset_enable <= wd[RBC_B0_RST_EN];
        end
    end
    // A crossing in the same cycle as a software clear still sets the flag
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            undervolt_event_flag <= nv_config[RBC_CFG_DET_EN]
                                  & ~nv_config[RBC_CFG_RST_EN] & below;
        end else if (crossing) begin
            undervolt_event_flag <= 1'h1;
        end else if (wr_bod0) begin
            undervolt_event_flag <= wd[RBC_B0_EVT];
        end
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            undervolt_reset_flag <= 1'h0;
        end else if (bor_rst) begin
            undervolt_reset_flag <= 1'h1;
        end else if (wr_bod0) begin
            undervolt_reset_flag <= wd[RBC_B0_RST_FLAG];
        end
    end
    assign undervolt_irq = undervolt_event_flag & irq_allowed;
    assign threshold_sel = thr_sel;

    // Secondary control: filter comes back enabled after reset
    always_ff @(posedge mclk) begin
        if (any_rst) begin
            detector_sampling_mode <= RBC_MODE_RST;
            detector_filter_enable <= RBC_FILT_RST;
        end else if (wr_bod1) begin
            detector_sampling_mode <= wd[RBC_B1_MODE_LO +: 2];
            detector_filter_enable <= wd[RBC_B1_FILT];
        end
    end

    // Pin reset flag: only power-on clears it from hardware, software clears by zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_reset_flag <= 1'h0;
        end else if (pin_rst) begin
            pin_reset_flag <= 1'h1;
        end else if (wr_aux) begin
            pin_reset_flag <= pin_reset_flag & wd[RBC_AUX_PIN];
        end
    end

    sequence s_pin_full;
        pin_st == RBC_PIN_COUNT && pin_low && pin_cnt == RBC_PIN_MIN_CYC - 5'h01;
    endsequence
    sequence s_pin_enter;
        pin_rst ##1 !sys_rst_n;
    endsequence

    property p_pin_detect;
        @(posedge mclk) disable iff (!rstn)
        s_pin_full |=> s_pin_enter;
    endproperty
    a_pin_detect: assert property (p_pin_detect)
        else $error("pin held low 24 cycles gave no reset");

    property p_pin_early;
        @(posedge mclk) disable iff (!rstn)
        $rose(pin_rst) |-> $past(pin_cnt) == RBC_PIN_MIN_CYC - 5'h01;
    endproperty
    a_pin_early: assert property (p_pin_early)
        else $error("pin reset entered before 24 low cycles");

    property p_pin_hold;
        @(posedge mclk) disable iff (!rstn)
        (pin_rst && pin_low) |=> pin_rst ##1 !sys_rst_n;
    endproperty
    a_pin_hold: assert property (p_pin_hold)
        else $error("reset left while pin still low");

    property p_bor;
        @(posedge mclk) disable iff (!rstn)
        bor_rst |=> !sys_rst_n && undervolt_reset_flag;
    endproperty
    a_bor: assert property (p_bor)
        else $error("brown-out gave no reset or no flag");

    property p_pinf;
        @(posedge mclk) disable iff (!rstn)
        pin_rst |=> pin_reset_flag;
    endproperty
    a_pinf: assert property (p_pinf)
        else $error("pin reset flag not set");

    property p_cold_keep;
        @(posedge mclk) disable iff (!rstn)
        (!sys_rst_n && !wr_pwr) |=> cold_start_flag == $past(cold_start_flag);
    endproperty
    a_cold_keep: assert property (p_cold_keep)
        else $error("cold-start flag changed by a warm reset");

    property p_evt_reset;
        @(posedge mclk) disable iff (!rstn)
        !sys_rst_n |=> undervolt_event_flag == ($past(nv_config[RBC_CFG_DET_EN])
            && !$past(nv_config[RBC_CFG_RST_EN]) && $past(below));
    endproperty
    a_evt_reset: assert property (p_evt_reset)
        else $error("event flag reset value wrong");

    property p_crossing;
        @(posedge mclk) disable iff (!rstn)
        (crossing && sys_rst_n) |=> undervolt_event_flag;
    endproperty
    a_crossing: assert property (p_crossing)
        else $error("threshold crossing did not set event flag");

    property p_ta_block;
        @(posedge mclk) disable iff (!rstn)
        (wr && hit(dph_idx, RBC_IDX_BOD1) && !ta_unlock && sys_rst_n)
            |=> $stable(detector_sampling_mode) && $stable(detector_filter_enable);
    endproperty
    a_ta_block: assert property (p_ta_block)
        else $error("locked write changed secondary control");

    property p_reload;
        @(posedge mclk) disable iff (!rstn)
        !sys_rst_n |=> detector_enable == $past(nv_config[RBC_CFG_DET_EN])
            && undervolt_reset_enable == $past(nv_config[RBC_CFG_RST_EN]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("enables not reloaded from config");
endmodule : rbc_ctrl

// >>> dv/rbc_cpu_model.sv
/*
 * Far-side model: the CPU that is reset and a reset button that drives the pin.
 * Assumes the pin has a pull-up, so it idles high between presses.
 */
`timescale 1ns/1ns
module rbc_cpu_model (
    input  wire logic        mclk,      // System clock
    input  wire logic        sys_rst_n, // System reset from the block
    input  wire logic [15:0] boot_addr, // Start address from the block
    input  wire logic        press,     // Pulse to start a press
    input  wire logic [7:0]  hold,      // Press length in clocks
    output logic             rst_pin_n, // Reset pin, pulled up when idle
    output int               boots,     // Reset releases seen
    output logic [15:0]      last_addr  // Start address at last release
);
    logic prev_rst_n = 1'b0;
    int   boot_cnt   = 0;
    assign boots = boot_cnt;
    initial begin
        rst_pin_n = 1'b1;
        forever begin
            @(posedge mclk);
            if (press) begin
                rst_pin_n <= 1'b0;
                repeat (hold) @(posedge mclk);
                rst_pin_n <= 1'b1;
            end
        end
    end
    always @(posedge mclk) begin
        prev_rst_n <= sys_rst_n;
        if (sys_rst_n && !prev_rst_n) begin
            boot_cnt <= boot_cnt + 1;
            last_addr <= boot_addr;
        end
    end
endmodule : rbc_cpu_model

// >>> dv/tb_top.sv
/*
 * Testbench for rbc_ctrl: register table, timed access, pin and brown-out resets.
 * Assumes the only AHB slave is the block, so hready is its own hreadyout.
 */
`timescale 1ns/1ns
module tb_top import rbc_pkg::*;;
    logic mclk = 0, rstn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, undervolt_raw = 0;
    logic slow_osc_clk = 0, ta_unlock = 1, sys_rst_n, clk_wake_req, undervolt_irq;
    logic rst_pin_n, press = 0, pd = 0, stable = 1;
    logic [7:0] nv_config = 8'h00, hold = 8'h00, q;
    logic [9:0] haddr = '0;
    logic [1:0] htrans = 2'h0, threshold_sel;
    logic [31:0] hwdata = '0, hrdata;
    logic [15:0] boot_addr, last_addr;
    int boots, miscompares = 0, cmp_count = 0;
    localparam logic [9:0] A_P = {RBC_IDX_PWR, 2'b00}, A_X = {RBC_IDX_AUX, 2'b00};
    localparam logic [9:0] A_0 = {RBC_IDX_BOD0, 2'b00}, A_1 = {RBC_IDX_BOD1, 2'b00};
    typedef struct {logic [9:0] a; logic w; logic [7:0] d; logic [7:0] e;} rbc_row_t;
    rbc_row_t rows [8] = '{'{A_P,0,8'h00,8'h10}, '{A_1,0,8'h00,8'h01}, '{A_0,0,8'h00,8'h00},
        '{A_P,1,8'hff,8'hdf}, '{A_P,1,8'h00,8'h00}, '{A_1,1,8'h07,8'h07},
        '{A_X,0,8'h00,8'h00}, '{10'h000,1,8'hff,8'h00}};
    rbc_ctrl dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .undervolt_raw(undervolt_raw),
        .rst_pin_n(rst_pin_n), .slow_osc_clk(slow_osc_clk), .nv_config(nv_config),
        .clk_is_slow(1'b0), .cpu_powerdown(pd), .clk_stable(stable), .ta_unlock(ta_unlock),
        .irq_allowed(1'b1), .sys_rst_n(sys_rst_n), .boot_addr(boot_addr),
        .clk_wake_req(clk_wake_req), .undervolt_irq(undervolt_irq),
        .threshold_sel(threshold_sel));
    rbc_cpu_model cpu (.mclk(mclk), .sys_rst_n(sys_rst_n), .boot_addr(boot_addr),
        .press(press), .hold(hold), .rst_pin_n(rst_pin_n), .boots(boots),
        .last_addr(last_addr));
    initial forever #2 mclk = ~mclk;
    initial forever begin
        repeat (8) @(posedge mclk);
        slow_osc_clk <= ~slow_osc_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
    endtask : bus
    task automatic pin(input logic [7:0] n); // Press the button for n clocks
        press <= 1'b1; hold <= n;
        @(posedge mclk); press <= 1'b0;
        repeat (80) @(posedge mclk);
    endtask : pin
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    initial begin
        #40000 miscompares++;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge mclk);
        chk(sys_rst_n, 1'b0);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        foreach (rows[i]) begin
            if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
            bus(rows[i].a, 1'b0, 8'h00);
            chk(q, rows[i].e);
        end
        $display("register table done");
        ta_unlock <= 1'b0;
        bus(A_1, 1'b1, 8'h00);
        bus(A_1, 1'b0, 8'h00);
        chk(q, 8'h07);
        chk(hresp, 1'b0);
        nv_config <= 8'hb4;
        pin(8'd10);
        chk(8'(boots), 8'd1);
        pin(8'd30);
        chk(8'(boots), 8'd2);
        chk(last_addr[7:0], 8'h00);
        bus(A_X, 1'b0, 8'h00);
        chk(q, 8'h40);
        bus(A_P, 1'b0, 8'h00);
        chk(q, 8'h00);
        bus(A_1, 1'b0, 8'h00);
        chk(q, 8'h01);
        bus(A_0, 1'b0, 8'h00);
        chk(q, 8'hb4);
        chk(threshold_sel, 2'h3);
        $display("pin reset done");
        undervolt_raw <= 1'b1;
        repeat (100) @(posedge mclk);
        chk(sys_rst_n, 1'b0);
        undervolt_raw <= 1'b0;
        repeat (200) @(posedge mclk);
        bus(A_0, 1'b0, 8'h00);
        chk(q & 8'h86, 8'h86);
        $display("brown-out reset done");
        pd <= 1'b1;
        stable <= 1'b0;
        press <= 1'b1;
        hold <= 8'h3c;
        @(posedge mclk);
        press <= 1'b0;
        repeat (20) @(posedge mclk);
        chk(clk_wake_req, 1'b1);
        chk(8'(boots), 8'h03);
        stable <= 1'b1;
        repeat (80) @(posedge mclk);
        chk(8'(boots), 8'h04);
        pd <= 1'b0;
        $display("power-down pin reset done");
        ta_unlock <= 1'b1;
        bus(A_0, 1'b1, 8'h80);
        undervolt_raw <= 1'b1;
        repeat (60) @(posedge mclk);
        bus(A_0, 1'b0, 8'h00);
        chk(q, 8'h89);
        chk(undervolt_irq, 1'b1);
        bus(A_0, 1'b1, 8'h80);
        bus(A_0, 1'b0, 8'h00);
        chk(q, 8'h81);
        chk(undervolt_irq, 1'b0);
        undervolt_raw <= 1'b0;
        repeat (60) @(posedge mclk);
        bus(A_0, 1'b0, 8'h00);
        chk(q, 8'h88);
        $display("event flag done");
        report_and_stop;
    end
endmodule : tb_top
